// file: design/udp_map.svh
// Purpose: constants of the one-wire debug link physical layer
// Assumes: 100 MHz system clock
// Notes:   counts derive from times in their own unit
`ifndef UDP_MAP_SVH
`define UDP_MAP_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define UDP_CLK_PERIOD_NS   10
`define UDP_SYS_MHZ         7'h64
`define UDP_T_WAKE_NS       10000
`define UDP_WAKE_CYC        ((`UDP_T_WAKE_NS + `UDP_CLK_PERIOD_NS - 1) / `UDP_CLK_PERIOD_NS)
`define UDP_T_SYNC_TMO_NS   13500000
`define UDP_SYNC_TMO_CYC    (`UDP_T_SYNC_TMO_NS / `UDP_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// link clock divider select field
// ----------------------------------------------------------------
`define UDP_SEL_16M         2'h1
`define UDP_SEL_8M          2'h2
`define UDP_SEL_4M          2'h3
`define UDP_SEL_DEFAULT     2'h3
`define UDP_MHZ_16          7'h10
`define UDP_MHZ_8           7'h08
`define UDP_MHZ_4           7'h04

// ----------------------------------------------------------------
// framing
// ----------------------------------------------------------------
`define UDP_SYNC_CHAR       8'h55
`define UDP_SYNC_FALLS      3'h4
`define UDP_SYNC_BITS_LOG2  3
`define UDP_FRAME_BITS      4'hc
`define UDP_BREAK_BITS      4'hc
`define UDP_IDX_START       4'h0
`define UDP_IDX_PARITY      4'h9
`define UDP_IDX_STOP1       4'ha
`define UDP_IDX_STOP2       4'hb
`define UDP_MIN_BIT_TICKS   4
`define UDP_DEF_BIT_TICKS   16'h4000

`endif

// file: design/udp_pkg.sv
// Purpose: state types of the one-wire debug link
// Assumes: nothing
// Notes:   encodings left to the tools
package udp_pkg;
  typedef enum logic [1:0] {LK_OFF, LK_WAKE, LK_WAIT_SYNC, LK_ON} udp_link_e;
  typedef enum logic [1:0] {RX_IDLE, RX_SYNC, RX_SYNC_END, RX_DATA} udp_rx_e;
  typedef enum logic       {TX_IDLE, TX_BIT} udp_tx_e;
endpackage

// file: design/udp_sync2.sv
// Purpose: two-flop level synchroniser
// Assumes: input may change at any time
// Notes:   first stage feeds only the second
module udp_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_sys_i,
  input  wire logic         arst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_ff <= '0;
      q_ff    <= '0;
    end else begin
      meta_ff <= d_i;
      q_ff    <= meta_ff;
    end
  end

  assign q_o = q_ff;
endmodule

// file: design/udp_clk_div.sv
// Purpose: fractional divider giving the link tick rate
// Assumes: select is stable while the link runs
// Notes:   phase accumulator, so 16/8/4 MHz need no integer ratio
`include "udp_map.svh"
module udp_clk_div import udp_pkg::*; (
  input  wire logic       clk_sys_i,
  input  wire logic       arst_n_i,
  input  wire logic [1:0] sel_i,
  output logic            tick_o
);
  logic [6:0] acc_ff;
  logic       tick_ff;
  logic [6:0] inc;
  logic [7:0] sum;

  always_comb begin
    case (sel_i)
      `UDP_SEL_16M: inc = `UDP_MHZ_16;
      `UDP_SEL_8M:  inc = `UDP_MHZ_8;
      default:      inc = `UDP_MHZ_4;
    endcase
    sum = {1'b0, acc_ff} + {1'b0, inc};
  end

  // ----------------------------------------------------------------
  // accumulator
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_ff  <= 7'h00;
      tick_ff <= 1'b0;
    end else if (sum >= {1'b0, `UDP_SYS_MHZ}) begin
      acc_ff  <= 7'(sum - {1'b0, `UDP_SYS_MHZ});
      tick_ff <= 1'b1;
    end else begin
      acc_ff  <= sum[6:0];
      tick_ff <= 1'b0;
    end
  end

  assign tick_o = tick_ff;
endmodule

// file: design/udp_link_phy.sv
// Purpose: one-wire half-duplex debug link, physical and uart layer
// Assumes: line_i already synchronous; debugger opens every exchange
// Notes:   link rate is a tick from a fractional divider of clk_sys_i
//
// Function
// - frames: low start, eight data, even parity, two high stops
// - wrong parity or low stop bit flags an error
// - parity check skipped while parity_check_disable is set
// - twelve high bit times equal an idle, resting line
// - twelve low bit times reset link logic to default
// - sync character 0x55 measures and sets the bit length
// - acknowledge sent once a store has crossed and gained the bus
// - measured rate serves receive and transmit of next byte
// - no baud register; start-aligned majority vote of mid samples
// - transmit uses exactly the receive bit length
// - link tick and bus side separated by a synchroniser
// - link clock starts at 4 MHz after enable or reset
// - link clock chosen by the divider select field
// - one shared pin, one driver at a time
// - access layer reaches memories and peripherals over the bus
// - system interface requests are served without bus request
// - after an error data, transmit, store and asi requests are ignored until break or link off
// - no sync within 13.5 ms of enable disables the link
`include "udp_map.svh"
module udp_link_phy import udp_pkg::*; #(
  parameter int unsigned CNT_W        = 16,
  parameter int unsigned SYNC_TMO_CYC = `UDP_SYNC_TMO_CYC,
  parameter logic [7:0]  ACK_CHAR     = 8'hac
) (
  input  wire logic             clk_sys_i,
  input  wire logic             arst_n_i,
  input  wire logic             line_i,
  output logic                  line_o,
  output logic                  line_oe_o,
  input  wire logic             parity_check_disable_i,
  input  wire logic [1:0]       link_clock_divider_select_i,
  input  wire logic             link_disable_i,
  input  wire logic             expect_sync_i,
  output logic [7:0]            rx_data_o,
  output logic                  rx_valid_o,
  input  wire logic [7:0]       tx_data_i,
  input  wire logic             tx_valid_i,
  output logic                  tx_ready_o,
  input  wire logic             store_req_i,
  output logic                  bus_req_o,
  input  wire logic             bus_grant_i,
  input  wire logic             asi_req_i,
  output logic                  asi_ack_o,
  output logic                  error_o,
  output logic                  parity_err_o,
  output logic                  frame_err_o,
  output logic                  contention_err_o,
  output logic                  break_o,
  output logic                  link_active_o,
  output logic [CNT_W-1:0]      bit_len_o
);
  localparam int unsigned SW = CNT_W + 3;
  localparam int unsigned BW = CNT_W + 4;

  udp_link_e            link_ff;
  udp_rx_e              rx_ff;
  udp_tx_e              tx_ff;
  logic [1:0]           sel_ff;
  logic                 tick;
  logic                 line_d_ff;
  logic                 grant_s;
  logic [31:0]          tmr_ff;
  logic [CNT_W-1:0]     bit_len_ff;
  logic [SW-1:0]        scnt_ff;
  logic [2:0]           falls_ff;
  logic [CNT_W-1:0]     rcnt_ff;
  logic [3:0]           ridx_ff;
  logic [2:0]           smp_ff;
  logic [7:0]           rsh_ff;
  logic                 rpar_ff;
  logic [BW-1:0]        low_ff;
  logic                 need_sync_ff;
  logic                 sync_done;
  logic                 sync_bad;
  logic                 brk;
  logic                 par_err;
  logic                 frm_err;
  logic                 con_err;
  logic [11:0]          tsh_ff;
  logic [3:0]           tidx_ff;
  logic [CNT_W-1:0]     tcnt_ff;
  logic                 ack_pend_ff;
  logic                 tx_ready_ff;
  logic                 line_o_ff;
  logic                 line_oe_ff;
  logic [7:0]           rx_data_ff;
  logic                 rx_valid_ff;
  logic                 err_ff;
  logic                 perr_ff;
  logic                 ferr_ff;
  logic                 cerr_ff;
  logic                 break_ff;
  logic                 bus_req_ff;
  logic                 asi_ack_ff;
  logic                 link_active_ff;
  logic                 fall;
  logic                 on;
  logic                 bit_vote;
  logic [CNT_W-1:0]     mid;
  logic [SW-1:0]        meas;
  logic                 accept;
  logic                 load_ack;

  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  function automatic logic [11:0] frame(input logic [7:0] d);
    frame = {2'b11, ^d, d, 1'b0};
  endfunction

  // ----------------------------------------------------------------
  // clocking and crossing
  // ----------------------------------------------------------------
  // divider select field
  udp_clk_div u_div (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .sel_i     (sel_ff),
    .tick_o    (tick)
  );

  udp_sync2 #(.W(1)) u_grant (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .d_i       (bus_grant_i),
    .q_o       (grant_s)
  );

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sel_ff <= `UDP_SEL_DEFAULT;
    end else if (link_ff == LK_OFF || link_ff == LK_WAKE) begin
      sel_ff <= `UDP_SEL_DEFAULT;
    end else if (link_clock_divider_select_i != 2'h0) begin
      sel_ff <= link_clock_divider_select_i;
    end
  end

  // own drive is not seen as a debugger edge
  assign fall     = line_d_ff & ~line_i & ~line_oe_ff;
  assign on       = (link_ff == LK_ON);
  assign mid      = bit_len_ff >> 1;
  assign bit_vote = maj3(smp_ff);
  assign meas     = scnt_ff >> `UDP_SYNC_BITS_LOG2;
  assign accept   = tx_valid_i & tx_ready_ff;
  assign load_ack = (tx_ff == TX_IDLE) & ack_pend_ff & ~accept & on & ~err_ff
                    & (rx_ff == RX_IDLE);

  // ----------------------------------------------------------------
  // enable sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      link_ff        <= LK_OFF;
      link_active_ff <= 1'b0;
      tmr_ff         <= 32'h0000_0000;
      line_d_ff      <= 1'b1;
    end else begin
      line_d_ff <= line_i;
      tmr_ff    <= tmr_ff + 32'h0000_0001;
      case (link_ff)
        LK_OFF: begin
          tmr_ff <= 32'h0000_0000;
          if (line_d_ff & ~line_i) begin
            link_ff <= LK_WAKE;
          end
        end
        LK_WAKE: begin
          if (tmr_ff == 32'(`UDP_WAKE_CYC - 1)) begin
            link_ff <= LK_WAIT_SYNC;
            tmr_ff  <= 32'h0000_0000;
          end
        end
        LK_WAIT_SYNC: begin
          // sync timeout or bad first sync
          if (sync_done) begin
            link_ff        <= LK_ON;
            link_active_ff <= 1'b1;
          end else if (sync_bad || (rx_ff == RX_IDLE && tmr_ff >= 32'(SYNC_TMO_CYC - 1))) begin
            link_ff <= LK_OFF;
          end
        end
        LK_ON: begin
          if (link_disable_i) begin
            link_ff        <= LK_OFF;
            link_active_ff <= 1'b0;
          end
        end
        default: begin
          link_ff        <= LK_OFF;
          link_active_ff <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // break detection
  // ----------------------------------------------------------------
  // twelve low bit times
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      low_ff <= '0;
    end else if (line_i | line_oe_ff | link_ff == LK_OFF) begin
      low_ff <= '0;
    end else if (tick && low_ff != '1) begin
      // saturates, so one long low gives one break
      low_ff <= low_ff + BW'(1);
    end
  end
  assign brk = (link_ff == LK_WAIT_SYNC || on) && tick &&
               (low_ff == BW'(bit_len_ff) * BW'(`UDP_BREAK_BITS) - BW'(1));

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_ff        <= RX_IDLE;
      scnt_ff      <= '0;
      falls_ff     <= 3'h0;
      rcnt_ff      <= '0;
      ridx_ff      <= 4'h0;
      smp_ff       <= 3'h0;
      rsh_ff       <= 8'h00;
      rpar_ff      <= 1'b0;
      bit_len_ff   <= CNT_W'(`UDP_DEF_BIT_TICKS);
      need_sync_ff <= 1'b1;
      rx_data_ff   <= 8'h00;
      rx_valid_ff  <= 1'b0;
    end else begin
      rx_valid_ff <= 1'b0;
      if (link_ff == LK_OFF || link_ff == LK_WAKE || brk) begin
        rx_ff        <= RX_IDLE;
        need_sync_ff <= 1'b1;
      end else begin
        // upper layer says when sync is due
        if (expect_sync_i) begin
          need_sync_ff <= 1'b1;
        end
        case (rx_ff)
          RX_IDLE: begin
            rcnt_ff  <= '0;
            ridx_ff  <= 4'h0;
            scnt_ff  <= '0;
            falls_ff <= 3'h0;
            if (fall && tx_ff == TX_IDLE) begin
              rx_ff <= need_sync_ff ? RX_SYNC : RX_DATA;
            end
          end
          // ticks over eight bits of 0x55
          RX_SYNC: begin
            if (tick && scnt_ff != '1) begin
              scnt_ff <= scnt_ff + SW'(1);
            end
            if (sync_bad) begin
              rx_ff <= RX_IDLE;
            end else if (fall) begin
              falls_ff <= falls_ff + 3'h1;
              if (falls_ff == `UDP_SYNC_FALLS - 3'h1) begin
                bit_len_ff   <= meas[CNT_W-1:0];
                need_sync_ff <= 1'b0;
                rcnt_ff      <= '0;
                rx_ff        <= RX_SYNC_END;
              end
            end
          end
          // skip last low bits of the sync, then wait out one high bit time
          RX_SYNC_END: begin
            if (!line_i) begin
              rcnt_ff <= '0;
            end else if (tick) begin
              rcnt_ff <= rcnt_ff + CNT_W'(1);
              if (rcnt_ff == bit_len_ff - CNT_W'(1)) begin
                rx_ff <= RX_IDLE;
              end
            end
          end
          RX_DATA: begin
            if (tick) begin
              rcnt_ff <= rcnt_ff + CNT_W'(1);
              if (rcnt_ff == mid - CNT_W'(1) || rcnt_ff == mid ||
                  rcnt_ff == mid + CNT_W'(1)) begin
                smp_ff <= {line_i, smp_ff[2:1]};
              end
              if (rcnt_ff == bit_len_ff - CNT_W'(1)) begin
                rcnt_ff <= '0;
                ridx_ff <= ridx_ff + 4'h1;
                if (ridx_ff == `UDP_IDX_START && bit_vote) begin
                  rx_ff <= RX_IDLE;
                end else if (ridx_ff < `UDP_IDX_PARITY) begin
                  rsh_ff <= {bit_vote, rsh_ff[7:1]};
                end else if (ridx_ff == `UDP_IDX_PARITY) begin
                  rpar_ff <= bit_vote;
                end
                if (ridx_ff == `UDP_IDX_STOP1 && !bit_vote) begin
                  rx_ff <= RX_IDLE;
                end
                if (ridx_ff == `UDP_IDX_STOP2) begin
                  rx_ff <= RX_IDLE;
                  if (!err_ff && !par_err && !frm_err) begin
                    rx_data_ff  <= rsh_ff;
                    rx_valid_ff <= 1'b1;
                  end
                end
              end
            end
          end
          default: rx_ff <= RX_IDLE;
        endcase
      end
    end
  end

  // a too short or overrun sync is not a rate
  assign sync_bad  = (rx_ff == RX_SYNC) &&
                     ((fall && falls_ff == `UDP_SYNC_FALLS - 3'h1 &&
                       meas < SW'(`UDP_MIN_BIT_TICKS)) || scnt_ff == '1);
  assign sync_done = (rx_ff == RX_SYNC) && fall && !sync_bad &&
                     (falls_ff == `UDP_SYNC_FALLS - 3'h1);

  assign par_err = (rx_ff == RX_DATA) && tick && (rcnt_ff == bit_len_ff - CNT_W'(1)) &&
                   (ridx_ff == `UDP_IDX_PARITY) && !parity_check_disable_i &&
                   (bit_vote != ^rsh_ff);
  assign frm_err = (rx_ff == RX_DATA) && tick && (rcnt_ff == bit_len_ff - CNT_W'(1)) &&
                   (ridx_ff == `UDP_IDX_STOP1 || ridx_ff == `UDP_IDX_STOP2) && !bit_vote;

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  // transmit only while receiver is idle
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_ff       <= TX_IDLE;
      tsh_ff      <= 12'hfff;
      tidx_ff     <= 4'h0;
      tcnt_ff     <= '0;
      tx_ready_ff <= 1'b0;
    end else begin
      tx_ready_ff <= (tx_ff == TX_IDLE) && on && !err_ff && !ack_pend_ff &&
                     (rx_ff == RX_IDLE) && !accept && !brk && !link_disable_i;
      if (brk || con_err || !on) begin
        tx_ff <= TX_IDLE;
      end else begin
        case (tx_ff)
          TX_IDLE: begin
            tidx_ff <= 4'h0;
            tcnt_ff <= '0;
            if (load_ack) begin
              tsh_ff <= frame(ACK_CHAR);
              tx_ff  <= TX_BIT;
            end else if (accept) begin
              tsh_ff <= frame(tx_data_i);
              tx_ff  <= TX_BIT;
            end
          end
          TX_BIT: begin
            if (tick) begin
              tcnt_ff <= tcnt_ff + CNT_W'(1);
              if (tcnt_ff == bit_len_ff - CNT_W'(1)) begin
                tcnt_ff <= '0;
                tsh_ff  <= {1'b1, tsh_ff[11:1]};
                tidx_ff <= tidx_ff + 4'h1;
                if (tidx_ff == `UDP_FRAME_BITS - 4'h1) begin
                  tx_ff <= TX_IDLE;
                end
              end
            end
          end
          default: tx_ff <= TX_IDLE;
        endcase
      end
    end
  end

  // line read back mid-bit catches a second driver
  assign con_err = (tx_ff == TX_BIT) && tick && line_oe_ff &&
                   (tcnt_ff == mid) && (line_i != line_o_ff);

  // drive only in wake pulse or own frame
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      line_o_ff  <= 1'b1;
      line_oe_ff <= 1'b0;
    end else begin
      line_oe_ff <= (link_ff == LK_WAKE) || (tx_ff == TX_BIT);
      line_o_ff  <= (link_ff == LK_WAKE) ? 1'b0 : tsh_ff[0];
    end
  end

  // ----------------------------------------------------------------
  // access layer handshakes
  // ----------------------------------------------------------------
  // store asks for the bus
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_req_ff  <= 1'b0;
      ack_pend_ff <= 1'b0;
    end else if (brk || !on) begin
      bus_req_ff  <= 1'b0;
      ack_pend_ff <= 1'b0;
    end else begin
      if (load_ack) begin
        ack_pend_ff <= 1'b0;
      end
      if (store_req_i && !err_ff) begin
        bus_req_ff <= 1'b1;
      end else if (bus_req_ff && grant_s) begin
        bus_req_ff  <= 1'b0;
        ack_pend_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      asi_ack_ff <= 1'b0;
    end else begin
      asi_ack_ff <= asi_req_i && on && !err_ff;
    end
  end

  // ----------------------------------------------------------------
  // error state
  // ----------------------------------------------------------------
  // sticky until break or link off; new error wins
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      err_ff   <= 1'b0;
      perr_ff  <= 1'b0;
      ferr_ff  <= 1'b0;
      cerr_ff  <= 1'b0;
      break_ff <= 1'b0;
    end else begin
      break_ff <= brk;
      if (brk || link_ff == LK_OFF) begin
        err_ff  <= 1'b0;
        perr_ff <= 1'b0;
        ferr_ff <= 1'b0;
        cerr_ff <= 1'b0;
      end
      if (par_err) begin
        perr_ff <= 1'b1;
        err_ff  <= 1'b1;
      end
      if (frm_err) begin
        ferr_ff <= 1'b1;
        err_ff  <= 1'b1;
      end
      if (con_err) begin
        cerr_ff <= 1'b1;
        err_ff  <= 1'b1;
      end
    end
  end

  assign line_o           = line_o_ff;
  assign line_oe_o        = line_oe_ff;
  assign rx_data_o        = rx_data_ff;
  assign rx_valid_o       = rx_valid_ff;
  assign tx_ready_o       = tx_ready_ff;
  assign bus_req_o        = bus_req_ff;
  assign asi_ack_o        = asi_ack_ff;
  assign error_o          = err_ff;
  assign parity_err_o     = perr_ff;
  assign frame_err_o      = ferr_ff;
  assign contention_err_o = cerr_ff;
  assign break_o          = break_ff;
  assign link_active_o    = link_active_ff;
  assign bit_len_o        = bit_len_ff;
endmodule

// file: bench/udp_link_phy_monitor.sv
// Purpose: port checker of the debug link phy
// Assumes: one clock domain
// Notes:   bound after the module
module udp_link_phy_monitor (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic parity_check_disable_i,
  input wire logic rx_valid_o,
  input wire logic tx_valid_i,
  input wire logic tx_ready_o,
  input wire logic store_req_i,
  input wire logic bus_req_o,
  input wire logic asi_req_i,
  input wire logic asi_ack_o,
  input wire logic error_o,
  input wire logic parity_err_o,
  input wire logic link_active_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  a_rx_pulse:
    assert property (rx_valid_o |=> !rx_valid_o) else $error("rx pulse long");
  a_err_blocks_rx:
    assert property (error_o |=> !rx_valid_o) else $error("rx during error");
  a_parity_err:
    assert property ($rose(parity_err_o) |-> ##[0:1] error_o) else $error("no error");
  a_parity_off:
    assert property ($rose(parity_err_o) |-> !$past(parity_check_disable_i))
      else $error("parity checked while off");
  a_asi_answer:
    assert property (asi_req_i && link_active_o && !error_o |=> asi_ack_o)
      else $error("no asi ack");
  a_tx_ready_gate:
    assert property (tx_ready_o |-> link_active_o && !error_o) else $error("ready gate");
  a_tx_accept_drop:
    assert property (tx_valid_i && tx_ready_o |=> !tx_ready_o) else $error("ready held");
  a_store_bus_req:
    assert property (store_req_i && link_active_o && !error_o |=> bus_req_o)
      else $error("no bus request");
  cover property (asi_ack_o);
  cover property (tx_valid_i && tx_ready_o);
  cover property (parity_err_o);
endmodule
bind udp_link_phy udp_link_phy_monitor mon_u (.clk_sys_i, .arst_n_i, .parity_check_disable_i,
  .rx_valid_o, .tx_valid_i, .tx_ready_o, .store_req_i, .bus_req_o, .asi_req_i, .asi_ack_o,
  .error_o, .parity_err_o, .link_active_o);

// file: bench/udp_dbg_model.sv
// Purpose: debugger side of the one-wire link
// Assumes: open drain line with pull-up
// Notes:   fixed bit time, a little slower than the device tick grid
module udp_dbg_model #(
  parameter int BT = 253
) (
  input  wire logic clk_i,
  input  wire logic line_i,
  output logic      pull_low_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pull_low_o = 1'b0;
  // frame lsb first, line rests high after
  task automatic send(input logic [7:0] b, input logic bad_par, input logic bad_stop);
    logic [11:0] f;
    f = {1'b1, ~bad_stop, ^b ^ bad_par, b, 1'b0};
    for (int i = 0; i < 12; i++) begin
      pull_low_o <= ~f[i];
      repeat (BT) @(posedge clk_i);
    end
  endtask
  task automatic brk();
    pull_low_o <= 1'b1;
    repeat (13 * BT) @(posedge clk_i);
    pull_low_o <= 1'b0;
    repeat (BT) @(posedge clk_i);
  endtask
  // short wake pulse, then wait for release
  task automatic wake();
    int n;
    n = 0;
    pull_low_o <= 1'b1;
    repeat (50) @(posedge clk_i);
    pull_low_o <= 1'b0;
    @(posedge clk_i);
    while (line_i !== 1'b1 && n < 5000) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  // mid-bit sampling of a device frame
  task automatic recv(output logic [7:0] b);
    int n;
    n = 0;
    while (line_i === 1'b1 && n < 40000) begin
      @(posedge clk_i);
      n++;
    end
    repeat (BT / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BT) @(posedge clk_i);
      b[i] = line_i;
    end
    repeat (4 * BT) @(posedge clk_i);
  endtask
endmodule

// file: bench/udp_link_phy_test.sv
// Purpose: directed bench of the debug link phy
// Assumes: 4 MHz link tick, debugger bit of 253 clocks
// Notes:   sync timeout cut to 2000 clocks
module udp_link_phy_test;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; \
    $display("[FAIL] %0t mismatch %h", $time, (a)); end end
  logic        clk_sys_i, arst_n_i, line_i, line_o, line_oe_o, pull_low, link_disable_i;
  logic        parity_check_disable_i, expect_sync_i, rx_valid_o, tx_valid_i, tx_ready_o;
  logic        store_req_i, bus_req_o, bus_grant_i, asi_req_i, asi_ack_o, error_o;
  logic        parity_err_o, frame_err_o, contention_err_o, break_o, link_active_o;
  logic [1:0]  link_clock_divider_select_i;
  logic [7:0]  rx_data_o, tx_data_i, rx_last, got;
  logic [15:0] bit_len_o;
  int          failures, comparisons, oe_cnt, rx_cnt, brk_cnt, asi_cnt;
  always #5 clk_sys_i = ~clk_sys_i;
  // wired line, either side pulls low
  assign line_i = ~pull_low & ~(line_oe_o & ~line_o);
  udp_link_phy #(.SYNC_TMO_CYC(2000)) dut_u (.clk_sys_i, .arst_n_i, .line_i, .line_o,
    .line_oe_o, .parity_check_disable_i, .link_clock_divider_select_i, .link_disable_i,
    .expect_sync_i, .rx_data_o, .rx_valid_o, .tx_data_i, .tx_valid_i, .tx_ready_o,
    .store_req_i, .bus_req_o, .bus_grant_i, .asi_req_i, .asi_ack_o, .error_o, .parity_err_o,
    .frame_err_o, .contention_err_o, .break_o, .link_active_o, .bit_len_o);
  udp_dbg_model m_u (.clk_i(clk_sys_i), .line_i, .pull_low_o(pull_low));
  always @(posedge clk_sys_i) begin
    if (line_oe_o) oe_cnt++;
    if (rx_valid_o) rx_cnt++;
    if (rx_valid_o) rx_last = rx_data_o;
    if (break_o) brk_cnt++;
    if (asi_ack_o) asi_cnt++;
  end
  task automatic end_sim();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic send_tx(input logic [7:0] b);
    int k;
    k = 0;
    tx_data_i <= b;
    tx_valid_i <= 1'b1;
    @(posedge clk_sys_i);
    while (tx_ready_o !== 1'b1 && k < 5000) begin
      @(posedge clk_sys_i);
      k++;
    end
    tx_valid_i <= 1'b0;
  endtask
  initial begin
    {clk_sys_i, arst_n_i, tx_valid_i, store_req_i, bus_grant_i, asi_req_i} = '0;
    {parity_check_disable_i, link_disable_i, expect_sync_i, tx_data_i} = '0;
    link_clock_divider_select_i = 2'h3;
    {failures, comparisons, oe_cnt, rx_cnt, brk_cnt, asi_cnt} = '0;
    repeat (3) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    `CHK(line_oe_o, 1'b0)
    `CHK(bit_len_o, 16'h4000)
    repeat (2) @(posedge clk_sys_i);
    m_u.wake();
    `CHK(oe_cnt, 1000)
    m_u.send(8'h55, 1'b0, 1'b0);
    `CHK(link_active_o, 1'b1)
    `CHK(bit_len_o, 16'h000a)
    asi_req_i <= 1'b1;
    @(posedge clk_sys_i);
    asi_req_i <= 1'b0;
    m_u.send(8'ha3, 1'b0, 1'b0);
    `CHK(rx_last, 8'ha3)
    `CHK(asi_cnt, 1)
    fork
      m_u.recv(got);
      send_tx(8'h3c);
    join
    `CHK(got, 8'h3c)
    `CHK(contention_err_o, 1'b0)
    store_req_i <= 1'b1;
    @(posedge clk_sys_i);
    store_req_i <= 1'b0;
    bus_grant_i <= 1'b1;
    m_u.recv(got);
    `CHK(got, 8'hac)
    bus_grant_i <= 1'b0;
    m_u.send(8'h5a, 1'b1, 1'b0);
    `CHK(parity_err_o, 1'b1)
    asi_req_i <= 1'b1;
    @(posedge clk_sys_i);
    asi_req_i <= 1'b0;
    m_u.send(8'h11, 1'b0, 1'b0);
    `CHK(rx_cnt, 1)
    `CHK(asi_cnt, 1)
    m_u.brk();
    `CHK(brk_cnt, 1)
    `CHK(error_o, 1'b0)
    m_u.send(8'h55, 1'b0, 1'b0);
    parity_check_disable_i <= 1'b1;
    m_u.send(8'h96, 1'b1, 1'b0);
    `CHK(rx_last, 8'h96)
    parity_check_disable_i <= 1'b0;
    expect_sync_i <= 1'b1;
    @(posedge clk_sys_i);
    expect_sync_i <= 1'b0;
    m_u.send(8'h55, 1'b0, 1'b0);
    `CHK(rx_cnt, 2)
    m_u.send(8'h0f, 1'b0, 1'b1);
    `CHK(frame_err_o, 1'b1)
    m_u.brk();
    m_u.brk();
    `CHK(frame_err_o, 1'b0)
    link_disable_i <= 1'b1;
    @(posedge clk_sys_i);
    link_disable_i <= 1'b0;
    m_u.wake();
    repeat (2100) @(posedge clk_sys_i);
    m_u.send(8'h55, 1'b0, 1'b0);
    `CHK(link_active_o, 1'b0)
    end_sim();
  end
  initial begin
    #800000;
    failures++;
    end_sim();
  end
endmodule
